/* include/cic_map.svh */
`ifndef CIC_MAP_SVH
`define CIC_MAP_SVH

// apb byte offsets
`define CIC_A_CTRL      8'h00
`define CIC_A_SUBCMD    8'h04
`define CIC_A_Q_LO      8'h08
`define CIC_A_Q_HI      8'h0c
`define CIC_A_TIME      8'h10
`define CIC_A_CCCUR     8'h14
`define CIC_A_ITEMP     8'h18
`define CIC_A_TSMEAS    8'h1c
`define CIC_A_CELLMV    8'h20
`define CIC_A_STACK     8'h24
`define CIC_A_CURR      8'h28
`define CIC_A_CAL_BASE  8'h40
`define CIC_A_CAL_WR    8'h80

// ctrl fields and reset
`define CIC_CTRL_CCM_LSB 0
`define CIC_CTRL_TSM_BIT 2
`define CIC_CCM_RST      2'h1
`define CIC_CCM_LOWPWR   2'h2
`define CIC_CCM_OFF      2'h3

// subcommands
`define CIC_SC_READOUT   16'h0004
`define CIC_SC_CLEAR     16'h0005

// calibration slots
`define CIC_NCAL         13
`define CIC_CAL_C1G      0
`define CIC_CAL_TOSG     5
`define CIC_CAL_CUROFF   6
`define CIC_CAL_CURG     7
`define CIC_CAL_CCOFF    8
`define CIC_CAL_CCG      9
`define CIC_CAL_TSOFF    10
`define CIC_CAL_ITOFF    11
`define CIC_CAL_ITG      12

// timing
`define CIC_CLK_HZ       100000000
`define CIC_LP_INT_S     4
`define CIC_LP_INT_CYC   (`CIC_LP_INT_S * `CIC_CLK_HZ)
`define CIC_STEP_MS      250
`define CIC_LP_SHIFT     4

`endif

/* include/cic_pkg.sv */
package cic_pkg;

	typedef enum logic [3:0] {
		CIC_PM_NORMAL   = 4'h1,
		CIC_PM_SLEEP    = 4'h2,
		CIC_PM_DEEP     = 4'h4,
		CIC_PM_SHUTDOWN = 4'h8
	} cic_pmode_t;

	typedef struct packed {
		logic        cc_valid;
		logic [15:0] cc_raw;
		logic        it_valid;
		logic [15:0] it_raw;
		logic        ts_valid;
		logic [15:0] ts_raw;
		logic        cell_valid;
		logic [2:0]  cell_idx;
		logic [15:0] cell_raw;
		logic        stk_valid;
		logic [15:0] stk_raw;
		logic        cur_valid;
		logic [23:0] cur_raw;
	} cic_meas_t;

endpackage

/* core/cic_core.sv */
// Overview of operation
// - add fast current into signed 48-bit charge
// - readout bytes 0-3: charge low 32
// - bytes 4-7: upper 16 sign-extended
// - 32-bit 250 ms normal-mode time counter
// - bytes 8-11: time counter little-endian
// - integrate only in normal, mode permitting
// - clear subcommand zeroes charge and time
// - config-update entry zeroes charge and time
// - low power: update once per 4 s
// - low power samples scaled to same units
// - die temp = (raw-off)*gain/65536
// - thermistor mode: bias while measured, regulator ref
// - analog-input mode: no bias, bandgap reference
// - sense pin result = raw minus offset
// - cell gain = cell1 gain plus delta
// - cells 4/5 and 6/7 share deltas
// - main gains held unsigned 16-bit
// - current offsets signed 16-bit
// - sense and temp offsets signed 16-bit
// - unwritten settings fall back to trim
// - cell mv = counts*gain/65536
`include "cic_map.svh"

module cic_core #(
	parameter int unsigned LP_INT_CYC = `CIC_LP_INT_CYC
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [12:0][15:0]     trim_val,
	input  cic_pkg::cic_meas_t         meas,
	input  cic_pkg::cic_pmode_t        power_mode,
	input  wire logic                  cfg_update_enter,
	input  wire logic                  ts_measuring,
	output logic                       ts_bias_en,
	output logic                       ts_ref_ldo
);

	// apb decode
	wire logic acc_w   = psel & penable & pwrite;
	wire logic a_ctrl  = paddr == `CIC_A_CTRL;
	wire logic a_sc    = paddr == `CIC_A_SUBCMD;
	wire logic a_cal   = paddr >= `CIC_A_CAL_BASE && paddr < 8'h74 && paddr[1:0] == 2'h0;
	wire logic [3:0] cal_i = 4'((paddr - `CIC_A_CAL_BASE) >> 2);
	wire logic a_ro    = paddr == `CIC_A_Q_LO || paddr == `CIC_A_Q_HI ||
	                     paddr == `CIC_A_TIME || paddr == `CIC_A_CCCUR ||
	                     paddr == `CIC_A_ITEMP || paddr == `CIC_A_TSMEAS ||
	                     paddr == `CIC_A_CELLMV || paddr == `CIC_A_STACK ||
	                     paddr == `CIC_A_CURR || paddr == `CIC_A_CAL_WR;
	wire logic mapped  = a_ctrl | a_sc | a_cal | a_ro;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	wire logic wr_ctrl  = acc_w & a_ctrl;
	wire logic wr_cal   = acc_w & a_cal;
	wire logic sc_read  = acc_w & a_sc & pwdata[15:0] == `CIC_SC_READOUT;
	wire logic sc_clear = acc_w & a_sc & pwdata[15:0] == `CIC_SC_CLEAR;

	// control register
	logic [1:0] ccm_q;
	logic       tsm_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ccm_q <= `CIC_CCM_RST;
			tsm_q <= 1'b0;
		end else if (wr_ctrl) begin
			ccm_q <= pwdata[`CIC_CTRL_CCM_LSB +: 2];
			tsm_q <= pwdata[`CIC_CTRL_TSM_BIT];
		end
	end

	// calibration storage with trim fallback
	logic [15:0]           cal_q [`CIC_NCAL];
	logic [`CIC_NCAL-1:0]  calw_q;
	logic [15:0]           cal_eff [`CIC_NCAL];

	genvar gi;
	generate
		for (gi = 0; gi < `CIC_NCAL; gi++) begin : g_cal
			wire logic hit = wr_cal & cal_i == 4'(gi);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cal_q[gi]  <= 16'h0000;
					calw_q[gi] <= 1'b0;
				end else if (hit) begin
					cal_q[gi]  <= pwdata[15:0];
					calw_q[gi] <= 1'b1;
				end
			end
			assign cal_eff[gi] = calw_q[gi] ? cal_q[gi] : trim_val[gi];
		end
	endgenerate

	// cell gains: slots 1..4 hold deltas for 2, 3, 4/5, 6/7
	logic [15:0] cell_gain [8];
	assign cell_gain[0] = cal_eff[`CIC_CAL_C1G];
	assign cell_gain[1] = cal_eff[`CIC_CAL_C1G];
	generate
		for (gi = 2; gi < 8; gi++) begin : g_cg
			localparam int DS = (gi <= 3) ? gi - 1 : (gi <= 5) ? 3 : 4;
			wire logic [7:0] dlt = cal_eff[DS][7:0];
			assign cell_gain[gi] = cal_eff[`CIC_CAL_C1G] + {{8{dlt[7]}}, dlt};
		end
	endgenerate

	// integration gating
	wire logic is_norm = power_mode == cic_pkg::CIC_PM_NORMAL;
	wire logic cc_on   = ccm_q != `CIC_CCM_OFF;
	wire logic lp      = ccm_q == `CIC_CCM_LOWPWR;
	logic [31:0] lp_cnt_q;
	wire logic lp_ok   = ~lp | lp_cnt_q == 32'h0;
	wire logic take    = meas.cc_valid & is_norm & cc_on & lp_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lp_cnt_q <= 32'h0;
		else if (!lp)
			lp_cnt_q <= 32'h0;
		else if (take)
			lp_cnt_q <= 32'(LP_INT_CYC - 1);
		else if (lp_cnt_q != 32'h0 && is_norm)
			lp_cnt_q <= lp_cnt_q - 32'h1;
	end

	// fast current calibration: (raw - off/256)*gain/32
	wire logic signed [15:0] cc_off = $signed(cal_eff[`CIC_CAL_CCOFF]);
	wire logic signed [17:0] cc_dif = 18'($signed(meas.cc_raw)) - 18'(cc_off >>> 8);
	wire logic signed [35:0] cc_prd = 36'(cc_dif) * $signed({20'h0, cal_eff[`CIC_CAL_CCG]});
	wire logic signed [15:0] cc_cur = cc_prd[20:5];

	// low power: one sample spans 16 steps of 250 ms
	wire logic signed [47:0] q_add = lp ? 48'(cc_cur) <<< `CIC_LP_SHIFT : 48'(cc_cur);
	wire logic [31:0]        t_add = lp ? 32'h10 : 32'h1;

	logic signed [47:0] q_q;
	logic [31:0]        t_q;
	logic [15:0]        cccur_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_q <= 48'h0;
			t_q <= 32'h0;
		end else if (sc_clear || cfg_update_enter) begin
			q_q <= 48'h0;
			t_q <= 32'h0;
		end else if (take) begin
			q_q <= q_q + q_add;
			t_q <= t_q + t_add;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cccur_q <= 16'h0;
		else if (take)
			cccur_q <= cc_cur;
	end

	// readout snapshot taken by the readout subcommand
	logic [31:0] rq_lo_q;
	logic [31:0] rq_hi_q;
	logic [31:0] rt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rq_lo_q <= 32'h0;
			rq_hi_q <= 32'h0;
			rt_q    <= 32'h0;
		end else if (sc_read) begin
			rq_lo_q <= q_q[31:0];
			rq_hi_q <= {{16{q_q[47]}}, q_q[47:32]};
			rt_q    <= t_q;
		end
	end

	// die temperature
	wire logic signed [16:0] it_dif = 17'($signed(meas.it_raw)) -
	                                  17'($signed(cal_eff[`CIC_CAL_ITOFF]));
	wire logic signed [33:0] it_prd = 34'(it_dif) * $signed({18'h0, cal_eff[`CIC_CAL_ITG]});
	logic [15:0] itemp_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			itemp_q <= 16'h0;
		else if (meas.it_valid)
			itemp_q <= it_prd[31:16];
	end

	// sense pin
	assign ts_bias_en = ~tsm_q & ts_measuring;
	assign ts_ref_ldo = ~tsm_q;
	logic [15:0] ts_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ts_q <= 16'h0;
		else if (meas.ts_valid)
			ts_q <= meas.ts_raw - cal_eff[`CIC_CAL_TSOFF];
	end

	// cell, stack and full current
	wire logic [31:0] cell_prd = meas.cell_raw * cell_gain[meas.cell_idx];
	wire logic [31:0] stk_prd  = meas.stk_raw * cal_eff[`CIC_CAL_TOSG];
	wire logic signed [24:0] cu_dif = 25'($signed(meas.cur_raw)) -
	                                  25'($signed(cal_eff[`CIC_CAL_CUROFF]));
	wire logic signed [42:0] cu_prd = 43'(cu_dif) * $signed({27'h0, cal_eff[`CIC_CAL_CURG]});
	logic [15:0] cell_q;
	logic [17:0] stk_q;
	logic [31:0] cur_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cell_q <= 16'h0;
		else if (meas.cell_valid)
			cell_q <= cell_prd[31:16];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stk_q <= 18'h0;
		else if (meas.stk_valid)
			stk_q <= stk_prd[31:14];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cur_q <= 32'h0;
		else if (meas.cur_valid)
			cur_q <= {{3{cu_prd[41]}}, cu_prd[41:13]};
	end

	// read mux
	always_comb begin
		prdata = 32'h0;
		if (a_cal)
			prdata = {16'h0, cal_eff[cal_i]};
		else
			case (paddr)
				`CIC_A_CTRL:   prdata = {29'h0, tsm_q, ccm_q};
				`CIC_A_Q_LO:   prdata = rq_lo_q;
				`CIC_A_Q_HI:   prdata = rq_hi_q;
				`CIC_A_TIME:   prdata = rt_q;
				`CIC_A_CCCUR:  prdata = {{16{cccur_q[15]}}, cccur_q};
				`CIC_A_ITEMP:  prdata = {{16{itemp_q[15]}}, itemp_q};
				`CIC_A_TSMEAS: prdata = {16'h0, ts_q};
				`CIC_A_CELLMV: prdata = {16'h0, cell_q};
				`CIC_A_STACK:  prdata = {14'h0, stk_q};
				`CIC_A_CURR:   prdata = cur_q;
				`CIC_A_CAL_WR: prdata = {19'h0, calw_q};
				default:       prdata = 32'h0;
			endcase
	end

endmodule

/* verification/cic_checker.sv */
module cic_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ts_measuring,
	input wire logic        ts_bias_en,
	input wire logic        ts_ref_ldo
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire ctl_wr = acc && pwrite && paddr == 8'h00;
	wire hole = paddr inside {8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};

	ready_in_access_a: assert property (acc |-> pready)
		else $error("pready low in access");
	err_in_access_a: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	hole_refused_a: assert property (acc && hole |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	ctrl_no_err_a: assert property (acc && paddr == 8'h00 |-> !pslverr)
		else $error("ctrl access refused");
	bias_gated_a: assert property (ts_bias_en |-> ts_measuring && ts_ref_ldo)
		else $error("bias outside measurement");
	bias_on_a: assert property (ts_measuring && ts_ref_ldo |-> ts_bias_en)
		else $error("bias missing");
	ref_follow_a: assert property (ctl_wr |=> ts_ref_ldo == !$past(pwdata[2]))
		else $error("reference select wrong");
	ref_hold_a: assert property (!ctl_wr |=> $stable(ts_ref_ldo))
		else $error("reference moved");
endmodule

bind cic_core cic_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .ts_measuring, .ts_bias_en, .ts_ref_ldo);

/* verification/cic_host.sv */
module cic_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {psel, penable, pwrite, paddr, pwdata} <= '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule

/* verification/cic_core_bench.sv */
module cic_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               pclk = 1'h0;
	logic               presetn = 1'h0;
	logic               cfg = 1'h0;
	logic               tsm = 1'h0;
	logic               psel, penable, pwrite, pready, pslverr, bias, ldo;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, r;
	logic [12:0][15:0]  trim = '0;
	cic_pkg::cic_meas_t  meas = '0;
	cic_pkg::cic_pmode_t pm = cic_pkg::CIC_PM_NORMAL;
	int                 miscompares = 0;
	int                 n_compared = 0;
	always #5 pclk = ~pclk;
	cic_core #(.LP_INT_CYC(20)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .trim_val(trim), .meas, .power_mode(pm),
		.cfg_update_enter(cfg), .ts_measuring(tsm), .ts_bias_en(bias), .ts_ref_ldo(ldo));
	cic_host u_host (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'h1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		u_host.xfer(1'h0, a, 32'h0, r);
		chk($sformatf("reg %h", a), e, r);
	endtask
	task automatic cc(input logic [15:0] v);
		@(posedge pclk);
		meas.cc_raw <= v;
		meas.cc_valid <= 1'h1;
		@(posedge pclk);
		meas.cc_valid <= 1'h0;
	endtask
	task automatic stb(input logic [2:0] idx);
		@(posedge pclk);
		meas.cell_idx <= idx;
		{meas.it_valid, meas.ts_valid, meas.cell_valid} <= 3'h7;
		@(posedge pclk);
		{meas.it_valid, meas.ts_valid, meas.cell_valid} <= 3'h0;
	endtask
	task automatic q(input logic [31:0] lo, hi, t);
		wr(8'h04, 32'h4);
		rd(8'h08, lo);
		rd(8'h0c, hi);
		rd(8'h10, t);
	endtask
	task conclude;
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100us;
		miscompares++;
		conclude;
	end
	initial begin
		trim[0] = 16'h8000;
		trim[3] = 16'hffff;
		trim[9] = 16'h0020;
		trim[10] = 16'h0010;
		trim[11] = 16'h0100;
		trim[12] = 16'h0800;
		meas.it_raw = 16'h1100;
		meas.ts_raw = 16'h0500;
		meas.cell_raw = 16'h1000;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		wr(8'h00, 32'h0);
		rd(8'h30, 32'h0);
		repeat (3) cc(16'hfff0);
		q(32'hffffffd0, 32'hffffffff, 32'h3);
		for (int i = 1; i < 4; i++) begin
			pm <= cic_pkg::cic_pmode_t'(4'h1 << i);
			cc(16'h0009);
		end
		pm <= cic_pkg::CIC_PM_NORMAL;
		wr(8'h00, 32'h3);
		cc(16'h0009);
		q(32'hffffffd0, 32'hffffffff, 32'h3);
		wr(8'h04, 32'h5);
		q(32'h0, 32'h0, 32'h0);
		wr(8'h00, 32'h0);
		cc(16'h0007);
		cfg <= 1'h1;
		@(posedge pclk);
		cfg <= 1'h0;
		q(32'h0, 32'h0, 32'h0);
		wr(8'h00, 32'h2);
		cc(16'h0005);
		cc(16'h0005);
		repeat (25) @(posedge pclk);
		cc(16'h0005);
		q(32'ha0, 32'h0, 32'h20);
		rd(8'h14, 32'h5);
		for (int i = 4; i < 8; i++) begin
			stb(3'(i));
			rd(8'h20, i < 6 ? 32'h7ff : 32'h800);
		end
		rd(8'h18, 32'h80);
		rd(8'h1c, 32'h4f0);
		rd(8'h70, 32'h800);
		wr(8'h70, 32'h400);
		rd(8'h80, 32'h1000);
		stb(3'h0);
		rd(8'h18, 32'h40);
		wr(8'h00, 32'h4);
		tsm <= 1'h1;
		@(posedge pclk);
		chk("bias", 32'h0, 32'(bias));
		chk("ref", 32'h0, 32'(ldo));
		wr(8'h00, 32'h0);
		@(posedge pclk);
		chk("bias", 32'h1, 32'(bias));
		chk("ref", 32'h1, 32'(ldo));
		conclude;
	end
endmodule
